// [verilog/bsq_top.sv]
// Purpose: mechanical brake release/engage sequencer and analog level output
// Assumes: drive loop inputs come from logic on i_ref_clk; Avalon-MM slave
// Notes: every access answers on the second cycle of the request
// Behaviour
// - brake control blocks start DC braking, dwell
// - scalar start ramps to fwd/rev release frequency
// - release when frequency and current reached
// - hold release frequency for release delay
// - scalar stop decelerates to engage frequency, engages
// - hold engage frequency for delay, then zero
// - configured DC braking after engage, then block
// - vector mode releases after pre-excitation time
// - vector acceleration waits release delay
// - vector stop decelerates to 0 Hz, engages
// - vector output cut after engage delay
// - no engage sequence in torque control
// - level source picks one of five inputs
// - output on above on level
// - output off below off level, capped
`timescale 1ns/100ps
`include "bsq_map.svh"

module bsq_top #(
	parameter int TICK_CYC = `BSQ_STEP_NS / `BSQ_CLK_NS
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_run_cmd,
	input wire logic i_reverse,
	input wire bsq_pkg::bsq_word16_t i_out_freq,
	input wire logic [11:0] i_motor_cur,
	input wire bsq_pkg::bsq_word16_t i_run_freq,
	input wire bsq_pkg::bsq_word16_t i_analog_0,
	input wire bsq_pkg::bsq_word16_t i_analog_1,
	input wire bsq_pkg::bsq_word16_t i_analog_2,
	input wire bsq_pkg::bsq_word16_t i_analog_3,
	input wire bsq_pkg::bsq_word16_t i_analog_4,
	output logic o_brake_release,
	output bsq_pkg::bsq_word16_t o_freq_ref,
	output logic o_freq_hold,
	output logic o_accel_enable,
	output logic o_out_enable,
	output logic o_dc_brake,
	output logic o_dc_start_inhibit,
	output logic o_dwell_inhibit,
	output logic o_level_out
);
	import bsq_pkg::*;

	logic [31:0] ctrl_q, relf_q, relc_q, dly_q, engf_q, dcb_q, prex_q, lvl_q, src_q;
	logic ack_q;
	logic [5:0] widx;
	logic acc;
	bsq_state_t state_q, state_d;
	logic [31:0] pre_q;
	logic [15:0] cnt_q;
	logic [15:0] dly_lim;
	logic dly_done;
	logic en, vec, trq;
	logic [15:0] rel_freq, on_lvl, off_eff, sel_val;
	logic rel_hit, eng_hit, dcb_set;

	assign widx = i_avs_address[7:2];
	assign acc = i_avs_read | i_avs_write;
	assign en = ctrl_q[`BSQ_C_EN];
	assign vec = ctrl_q[`BSQ_C_VEC];
	assign trq = ctrl_q[`BSQ_C_TRQ];

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// waitrequest high in the first request cycle, low in the second
	assign o_avs_waitrequest = acc & ~ack_q;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= acc & ~ack_q;
		end
	end

	// register writes, taken in the cycle waitrequest is low
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			ctrl_q <= `BSQ_R_CTRL;
			relf_q <= `BSQ_R_RELF;
			relc_q <= `BSQ_R_RELC;
			dly_q <= `BSQ_R_DLY;
			engf_q <= `BSQ_R_ENGF;
			dcb_q <= `BSQ_R_DCB;
			prex_q <= `BSQ_R_PREX;
			lvl_q <= `BSQ_R_LVL;
			src_q <= `BSQ_R_SRC;
		end else if (i_avs_write && ack_q) begin
			case (widx)
				`BSQ_A_CTRL: ctrl_q <= merge(ctrl_q, i_avs_writedata, i_avs_byteenable);
				`BSQ_A_RELF: relf_q <= merge(relf_q, i_avs_writedata, i_avs_byteenable);
				`BSQ_A_RELC: relc_q <= merge(relc_q, i_avs_writedata, i_avs_byteenable);
				`BSQ_A_DLY: dly_q <= merge(dly_q, i_avs_writedata, i_avs_byteenable);
				`BSQ_A_ENGF: engf_q <= merge(engf_q, i_avs_writedata, i_avs_byteenable);
				`BSQ_A_DCB: dcb_q <= merge(dcb_q, i_avs_writedata, i_avs_byteenable);
				`BSQ_A_PREX: prex_q <= merge(prex_q, i_avs_writedata, i_avs_byteenable);
				`BSQ_A_LVL: lvl_q <= merge(lvl_q, i_avs_writedata, i_avs_byteenable);
				`BSQ_A_SRC: begin
					if (i_avs_byteenable[0] && i_avs_writedata[`BSQ_SEL] <= `BSQ_SRC_MAX) begin
						src_q <= {29'h0, i_avs_writedata[`BSQ_SEL]};
					end
				end
				default: ;
			endcase
		end
	end

	// read data registered in the waiting cycle; unmapped words read zero
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_avs_readdata <= 32'h0;
		end else if (i_avs_read && !ack_q) begin
			case (widx)
				`BSQ_A_CTRL: o_avs_readdata <= ctrl_q;
				`BSQ_A_RELF: o_avs_readdata <= relf_q;
				`BSQ_A_RELC: o_avs_readdata <= relc_q;
				`BSQ_A_DLY: o_avs_readdata <= dly_q;
				`BSQ_A_ENGF: o_avs_readdata <= engf_q;
				`BSQ_A_DCB: o_avs_readdata <= dcb_q;
				`BSQ_A_PREX: o_avs_readdata <= prex_q;
				`BSQ_A_LVL: o_avs_readdata <= lvl_q;
				`BSQ_A_SRC: o_avs_readdata <= src_q;
				`BSQ_A_STAT: o_avs_readdata <= {26'h0, o_level_out, o_brake_release, state_q};
				default: o_avs_readdata <= 32'h0;
			endcase
		end
	end

	// sequence thresholds
	assign rel_freq = i_reverse ? relf_q[`BSQ_HI] : relf_q[`BSQ_LO];
	assign rel_hit = i_out_freq >= rel_freq && i_motor_cur >= relc_q[`BSQ_CUR];
	assign eng_hit = vec ? i_out_freq == `BSQ_ZERO_F : i_out_freq <= engf_q[`BSQ_LO];
	assign dcb_set = dcb_q[`BSQ_LO] != 16'h0 && dcb_q[`BSQ_HI] != 16'h0;

	// delay length for the current state, in 10 ms steps
	always_comb begin
		case (state_q)
			BSQ_PREX: dly_lim = prex_q[`BSQ_LO];
			BSQ_RDLY: dly_lim = dly_q[`BSQ_LO];
			BSQ_EDLY: dly_lim = dly_q[`BSQ_HI];
			BSQ_DCB: dly_lim = dcb_q[`BSQ_LO];
			default: dly_lim = 16'h0;
		endcase
	end
	assign dly_done = cnt_q >= dly_lim;

	// step counter, restarted on every state change
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n || state_d != state_q) begin
			pre_q <= 32'h0;
			cnt_q <= 16'h0;
		end else if (pre_q == 32'(TICK_CYC - 1)) begin
			pre_q <= 32'h0;
			if (cnt_q != `BSQ_CNT_MAX) begin
				cnt_q <= cnt_q + 16'h1;
			end
		end else begin
			pre_q <= pre_q + 32'h1;
		end
	end

	// brake sequence next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			BSQ_IDLE: if (i_run_cmd) begin
				state_d = vec ? BSQ_PREX : BSQ_RAMP;
			end
			BSQ_PREX: if (!i_run_cmd) begin
				state_d = BSQ_BLOCK;
			end else if (dly_done) begin
				state_d = BSQ_RDLY;
			end
			BSQ_RAMP: if (!i_run_cmd) begin
				state_d = BSQ_BLOCK;
			end else if (rel_hit) begin
				state_d = BSQ_RDLY;
			end
			BSQ_RDLY: if (dly_done) begin
				state_d = BSQ_RUN;
			end
			BSQ_RUN: if (!i_run_cmd) begin
				state_d = trq ? BSQ_BLOCK : BSQ_DECEL;
			end
			BSQ_DECEL: if (i_run_cmd) begin
				state_d = BSQ_RUN;
			end else if (eng_hit) begin
				state_d = BSQ_EDLY;
			end
			BSQ_EDLY: if (dly_done) begin
				state_d = (!vec && dcb_set) ? BSQ_DCB : BSQ_BLOCK;
			end
			BSQ_DCB: if (dly_done) begin
				state_d = BSQ_BLOCK;
			end
			BSQ_BLOCK: state_d = BSQ_IDLE;
			default: state_d = BSQ_IDLE;
		endcase
		if (!en) begin
			state_d = BSQ_IDLE;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			state_q <= BSQ_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// drive-side outputs, registered from the next state
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_brake_release <= 1'b0;
			o_freq_ref <= `BSQ_ZERO_F;
			o_freq_hold <= 1'b0;
			o_accel_enable <= 1'b0;
			o_out_enable <= 1'b0;
			o_dc_brake <= 1'b0;
			o_dc_start_inhibit <= 1'b0;
			o_dwell_inhibit <= 1'b0;
		end else begin
			o_dc_start_inhibit <= en;
			o_dwell_inhibit <= en;
			o_brake_release <= state_d == BSQ_RDLY || state_d == BSQ_RUN ||
				state_d == BSQ_DECEL;
			o_freq_hold <= state_d == BSQ_PREX || state_d == BSQ_RDLY ||
				state_d == BSQ_EDLY;
			o_accel_enable <= !en || state_d == BSQ_RAMP || state_d == BSQ_RUN ||
				state_d == BSQ_DECEL;
			o_out_enable <= en ? !(state_d == BSQ_IDLE || state_d == BSQ_BLOCK) : i_run_cmd;
			o_dc_brake <= state_d == BSQ_DCB;
			case (state_d)
				BSQ_IDLE: o_freq_ref <= en ? `BSQ_ZERO_F : i_run_freq;
				BSQ_RAMP: o_freq_ref <= rel_freq;
				BSQ_RDLY: o_freq_ref <= vec ? `BSQ_ZERO_F : rel_freq;
				BSQ_RUN: o_freq_ref <= i_run_freq;
				BSQ_DECEL: o_freq_ref <= vec ? `BSQ_ZERO_F : engf_q[`BSQ_LO];
				BSQ_EDLY: o_freq_ref <= vec ? `BSQ_ZERO_F : engf_q[`BSQ_LO];
				default: o_freq_ref <= `BSQ_ZERO_F;
			endcase
		end
	end

	// level output with hysteresis; off level capped at on level
	assign on_lvl = lvl_q[`BSQ_LO];
	assign off_eff = lvl_q[`BSQ_HI] > on_lvl ? on_lvl : lvl_q[`BSQ_HI];
	always_comb begin
		case (src_q[`BSQ_SEL])
			3'h0: sel_val = i_analog_0;
			3'h1: sel_val = i_analog_1;
			3'h2: sel_val = i_analog_2;
			3'h3: sel_val = i_analog_3;
			3'h4: sel_val = i_analog_4;
			default: sel_val = i_analog_1;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_level_out <= 1'b0;
		end else if (!ctrl_q[`BSQ_C_LVL]) begin
			o_level_out <= 1'b0;
		end else if (sel_val > on_lvl) begin
			o_level_out <= 1'b1;
		end else if (sel_val < off_eff) begin
			o_level_out <= 1'b0;
		end
	end

	// checks
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	inhibit_follow_a: assert property (en |=> o_dc_start_inhibit && o_dwell_inhibit)
		else $error("inhibits not raised with brake control");
	ramp_ref_a: assert property (state_q == BSQ_RAMP && $stable(rel_freq) |->
		o_freq_ref == rel_freq)
		else $error("ramp reference is not the release frequency");
	release_cause_a: assert property ($rose(o_brake_release) && !$past(vec) |->
		$past(state_q == BSQ_RAMP && rel_hit))
		else $error("release without frequency and current");
	accel_wait_a: assert property ($rose(o_accel_enable) && en && $past(en) &&
		o_brake_release |-> $past(state_q) == BSQ_RDLY && $past(dly_done))
		else $error("acceleration before the release delay ran out");
	engage_cause_a: assert property ($fell(o_brake_release) && $past(en) &&
		!$past(vec) && !$past(trq) && $past(state_q) == BSQ_DECEL |->
		$past(i_out_freq <= engf_q[`BSQ_LO])) else $error("engage above engage frequency");
	block_zero_a: assert property (state_q == BSQ_BLOCK |-> o_freq_ref == `BSQ_ZERO_F)
		else $error("frequency not zero when blocked");
	dcb_engaged_a: assert property (o_dc_brake |-> !o_brake_release && o_out_enable)
		else $error("DC braking with brake released");
	prex_first_a: assert property ($rose(o_brake_release) && $past(vec) |->
		$past(state_q) == BSQ_PREX)
		else $error("vector release before pre-excitation");
	vec_zero_a: assert property ($past(state_q) == BSQ_DECEL && state_q == BSQ_EDLY &&
		vec |-> $past(i_out_freq) == `BSQ_ZERO_F)
		else $error("vector engage above 0 Hz");
	torque_skip_a: assert property (state_q == BSQ_RUN && trq && !i_run_cmd && en |=>
		state_q == BSQ_BLOCK)
		else $error("engage sequence ran in torque mode");
	level_on_a: assert property (ctrl_q[`BSQ_C_LVL] && sel_val > on_lvl |=> o_level_out)
		else $error("level output not on");
	level_hold_a: assert property (ctrl_q[`BSQ_C_LVL] && $past(ctrl_q[`BSQ_C_LVL]) &&
		$past(sel_val) <= $past(on_lvl) && $past(sel_val) >= $past(off_eff) |->
		$stable(o_level_out))
		else $error("level output changed between levels");

	cv_scalar: cover property (state_q == BSQ_RDLY ##1 state_q == BSQ_RUN && !vec);
	cv_vector: cover property (state_q == BSQ_PREX && vec ##1 state_q == BSQ_RDLY);
	cv_dcb: cover property (state_q == BSQ_DCB ##1 state_q == BSQ_BLOCK);
	cv_level: cover property ($rose(o_level_out) ##[1:50] $fell(o_level_out));
endmodule // bsq_top

// [inc/bsq_map.svh]
// Purpose: register map, reset values and timing figures of the brake sequencer
// Assumes: 32-bit Avalon-MM words at byte offsets, frequencies in 0.01 Hz,
//          currents in 0.1 %, analog levels in 0.01 %, delays in 10 ms steps
// Notes: included by the sequencer top only
`ifndef BSQ_MAP_SVH
`define BSQ_MAP_SVH

// register word index (byte offset / 4)
`define BSQ_A_CTRL 6'h00
`define BSQ_A_RELF 6'h01
`define BSQ_A_RELC 6'h02
`define BSQ_A_DLY 6'h03
`define BSQ_A_ENGF 6'h04
`define BSQ_A_DCB 6'h05
`define BSQ_A_PREX 6'h06
`define BSQ_A_LVL 6'h07
`define BSQ_A_SRC 6'h08
`define BSQ_A_STAT 6'h09

// field positions
`define BSQ_LO 15:0
`define BSQ_HI 31:16
`define BSQ_CUR 11:0
`define BSQ_SEL 2:0
`define BSQ_ST 3:0
`define BSQ_C_EN 0
`define BSQ_C_VEC 1
`define BSQ_C_TRQ 2
`define BSQ_C_LVL 3
`define BSQ_S_REL 4
`define BSQ_S_LVL 5

// reset values
`define BSQ_R_CTRL 32'h0000_0000
`define BSQ_R_RELF 32'h0064_0064
`define BSQ_R_RELC 32'h0000_01f4
`define BSQ_R_DLY 32'h0064_0064
`define BSQ_R_ENGF 32'h0000_00c8
`define BSQ_R_DCB 32'h0000_0000
`define BSQ_R_PREX 32'h0000_000a
`define BSQ_R_LVL 32'h03e8_2328
`define BSQ_R_SRC 32'h0000_0001
`define BSQ_SRC_MAX 3'h4

// timing: one delay step in ns, clock period in ns
`define BSQ_STEP_NS 10000000
`define BSQ_CLK_NS 10
`define BSQ_CNT_MAX 16'hffff
`define BSQ_ZERO_F 16'h0000

`endif

// [inc/bsq_pkg.sv]
// Purpose: types shared by the brake sequencer
// Assumes: nothing
// Notes: state codes are the enum defaults, 0 to 8 in listed order, read back in the status word
package bsq_pkg;
	typedef enum logic [3:0] {
		BSQ_IDLE, BSQ_PREX, BSQ_RAMP, BSQ_RDLY, BSQ_RUN,
		BSQ_DECEL, BSQ_EDLY, BSQ_DCB, BSQ_BLOCK
	} bsq_state_t;
	typedef logic [15:0] bsq_word16_t;
endpackage

// [sim/bsq_drive_model.sv]
// Purpose: drive loop and brake relay seen from the sequencer
// Assumes: output frequency slews toward the reference in fixed steps
// Notes: frequency drops to 0 at once while the output is blocked
`timescale 1ns/100ps
module bsq_drive_model #(
	parameter int STEP = 25
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire bsq_pkg::bsq_word16_t i_freq_ref,
	input wire logic i_out_enable,
	input wire logic i_release,
	output bsq_pkg::bsq_word16_t o_out_freq,
	output logic o_brake_open
);
	import bsq_pkg::*;
	// slew the output frequency toward the reference
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !i_out_enable) begin
			o_out_freq <= 16'h0000;
		end else if (int'(o_out_freq) + STEP <= int'(i_freq_ref)) begin
			o_out_freq <= o_out_freq + 16'(STEP);
		end else if (int'(o_out_freq) >= int'(i_freq_ref) + STEP) begin
			o_out_freq <= o_out_freq - 16'(STEP);
		end else begin
			o_out_freq <= i_freq_ref;
		end
	end
	// relay contact lags the coil by one cycle
	always_ff @(posedge i_clk) begin
		o_brake_open <= i_rst_n & i_release;
	end
endmodule // bsq_drive_model

// [sim/testbench.sv]
// Purpose: self-checking bench of the brake sequencer
// Assumes: delay step shortened to 4 cycles
// Notes: bus sampled at the rising edge, flags at the falling edge
`timescale 1ns/100ps
module testbench;
	import bsq_pkg::*;
	localparam int TK = 4;
	logic clk = 0, rst_n = 0, rd = 0, wr = 0, run = 0, rev = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0000_0000, q;
	logic [11:0] cur = 12'h000;
	bsq_word16_t an [5] = '{default: 16'h0000};
	bsq_word16_t runf = 16'h03e8;
	bsq_word16_t ofreq, fref;
	logic [31:0] rdata;
	logic wreq, rel, hold, acc, oen, dcb, dci, dwi, lvl;
	int error_cnt = 0, checks = 0, n;
	logic [7:0] ra [11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20,
		8'h24, 8'h3c};
	logic [31:0] rv [11] = '{32'h0000_0000, 32'h0064_0064, 32'h0000_01f4, 32'h0064_0064,
		32'h0000_00c8, 32'h0000_0000, 32'h0000_000a, 32'h03e8_2328, 32'h0000_0001,
		32'h0000_0000, 32'h0000_0000};
	// clock
	always #5 clk = ~clk;
	bsq_top #(.TICK_CYC(TK)) bsq_top_i(.i_ref_clk(clk), .i_rst_n(rst_n), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_run_cmd(run), .i_reverse(rev),
		.i_out_freq(ofreq), .i_motor_cur(cur), .i_run_freq(runf), .i_analog_0(an[0]),
		.i_analog_1(an[1]), .i_analog_2(an[2]), .i_analog_3(an[3]), .i_analog_4(an[4]),
		.o_brake_release(rel), .o_freq_ref(fref), .o_freq_hold(hold), .o_accel_enable(acc),
		.o_out_enable(oen), .o_dc_brake(dcb), .o_dc_start_inhibit(dci),
		.o_dwell_inhibit(dwi), .o_level_out(lvl));
	bsq_drive_model bsq_drive_model_i(.i_clk(clk), .i_rst_n(rst_n), .i_freq_ref(fref),
		.i_out_enable(oen), .i_release(rel), .o_out_freq(ofreq), .o_brake_open());
	// compare and count
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one Avalon access, held until waitrequest is sampled low at a rising edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		rd <= ~w;
		wr <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk);
			k++;
		end while (wreq !== 1'b0 && k < 20);
		if (wreq !== 1'b0) chk("waitrequest", 1'b1, 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(nm, q, e);
	endtask
	function automatic logic sig(input int s);
		case (s)
			0: return rel;
			1: return acc;
			2: return oen;
			default: return dcb;
		endcase
	endfunction
	// count cycles until a flag takes a level
	task waitc(input int s, input logic v);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (sig(s) !== v && n < 400);
		if (n >= 400) chk("flag wait", 1'b0, v);
	endtask
	// selected input gets v, the others its opposite
	task lv(input int s, input bsq_word16_t v, input logic e);
		@(posedge clk);
		for (int i = 0; i < 5; i++) an[i] <= (i == s) ? v : 16'h2710 - v;
		repeat (3) @(negedge clk);
		chk("level out", lvl, e);
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// watchdog
	initial begin
		#500000;
		error_cnt++;
		report_and_stop;
	end
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 11; i++) rdchk("reset word", ra[i], rv[i]);
		chk("inhibit idle", dci, 1'b0);
		$display("test reset values done");
		bus(1'b1, 8'h0c, 32'h0002_0002);
		bus(1'b1, 8'h14, 32'h0001_0001);
		bus(1'b1, 8'h00, 32'h0000_0001);
		run <= 1'b1;
		repeat (20) @(negedge clk);
		chk("release early", rel, 1'b0);
		chk("ramp ref", fref, 16'h0064);
		chk("start inhibit", dci, 1'b1);
		chk("dwell inhibit", dwi, 1'b1);
		@(posedge clk);
		cur <= 12'h258;
		waitc(0, 1'b1);
		chk("release soon", n <= 3, 1'b1);
		chk("release hold", hold, 1'b1);
		waitc(1, 1'b1);
		chk("release delay", n >= 2 * TK, 1'b1);
		repeat (50) @(posedge clk);
		run <= 1'b0;
		waitc(0, 1'b0);
		chk("engage ref", fref, 16'h00c8);
		chk("engage freq", ofreq <= 16'h00c8, 1'b1);
		waitc(3, 1'b1);
		chk("engage delay", n >= 2 * TK, 1'b1);
		waitc(2, 1'b0);
		chk("dc brake end", dcb, 1'b0);
		bus(1'b1, 8'h04, 32'h012c_0064);
		bus(1'b1, 8'h14, 32'h0000_0000);
		rev <= 1'b1;
		run <= 1'b1;
		waitc(0, 1'b1);
		chk("reverse ref", fref, 16'h012c);
		@(posedge clk);
		run <= 1'b0;
		waitc(2, 1'b0);
		$display("test scalar done");
		bus(1'b1, 8'h18, 32'h0000_0001);
		bus(1'b1, 8'h00, 32'h0000_0003);
		rev <= 1'b0;
		run <= 1'b1;
		waitc(0, 1'b1);
		chk("prex wait", n >= TK, 1'b1);
		waitc(1, 1'b1);
		chk("vector delay", n >= 2 * TK, 1'b1);
		repeat (50) @(posedge clk);
		run <= 1'b0;
		waitc(0, 1'b0);
		chk("zero freq", ofreq, 16'h0000);
		waitc(2, 1'b0);
		chk("cut delay", n >= 2 * TK, 1'b1);
		bus(1'b1, 8'h00, 32'h0000_0007);
		run <= 1'b1;
		waitc(1, 1'b1);
		@(posedge clk);
		run <= 1'b0;
		repeat (3) @(negedge clk);
		chk("torque release", rel, 1'b0);
		chk("torque cut", oen, 1'b0);
		$display("test vector done");
		bus(1'b1, 8'h00, 32'h0000_0008);
		lv(1, 16'h251c, 1'b1);
		lv(1, 16'h1388, 1'b1);
		lv(1, 16'h01f4, 1'b0);
		lv(1, 16'h1388, 1'b0);
		lv(1, 16'h2328, 1'b0);
		lv(1, 16'h2329, 1'b1);
		bus(1'b1, 8'h1c, 32'h2328_1388);
		lv(1, 16'h1770, 1'b1);
		lv(1, 16'h1387, 1'b0);
		bus(1'b1, 8'h1c, 32'h03e8_2328);
		for (int s = 0; s < 5; s++) begin
			bus(1'b1, 8'h20, 32'(s));
			lv(s, 16'h251c, 1'b1);
			lv(s, 16'h0064, 1'b0);
		end
		bus(1'b1, 8'h20, 32'h0000_0005);
		rdchk("source refused", 8'h20, 32'h0000_0004);
		$display("test level done");
		bus(1'b1, 8'h00, 32'h0000_0001);
		run <= 1'b1;
		waitc(0, 1'b1);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(negedge clk);
		chk("reset release", rel, 1'b0);
		chk("reset output", oen, 1'b0);
		@(posedge clk);
		rst_n <= 1'b1;
		run <= 1'b0;
		rdchk("ctrl after reset", 8'h00, 32'h0000_0000);
		$display("test mid reset done");
		report_and_stop;
	end
endmodule // testbench
